// [design/ssx_pkg.sv]
// constants for the subtract / swap / table read execution block
// shared by the execution module and by anything that decodes its bus map
package ssx_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned PM_W   = 24;
	localparam int unsigned PAGE_W = 8;
	localparam int unsigned NREG   = 16;

	// opcode patterns
	localparam logic [4:0] OPC_RSUB = 5'h02;
	localparam logic [8:0] OPC_TBLH = 9'h175;
	localparam logic [8:0] OPC_SWAP = 9'h1fb;
	localparam logic [9:0] SWAP_ZERO = 10'h000;

	// field positions
	localparam int F_OP5_LO  = 19;
	localparam int F_OP9_LO  = 15;
	localparam int F_BASE_HI = 18;
	localparam int F_BASE_LO = 15;
	localparam int F_BYTE    = 14;
	localparam int F_DMD_HI  = 13;
	localparam int F_DMD_LO  = 11;
	localparam int F_DRG_HI  = 10;
	localparam int F_DRG_LO  = 7;
	localparam int F_SMD_HI  = 6;
	localparam int F_SMD_LO  = 4;
	localparam int F_SRG_HI  = 3;
	localparam int F_SRG_LO  = 0;
	localparam int F_ZERO_HI = 13;
	localparam int F_ZERO_LO = 4;

	// addressing modes
	localparam logic [2:0] MD_DIRECT   = 3'h0;
	localparam logic [2:0] MD_INDIRECT = 3'h1;
	localparam logic [2:0] MD_POST_DEC = 3'h2;
	localparam logic [2:0] MD_POST_INC = 3'h3;
	localparam logic [2:0] MD_PRE_DEC  = 3'h4;
	localparam logic [2:0] MD_PRE_INC  = 3'h5;

	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;

	// flag word bit positions
	localparam int FL_C  = 0;
	localparam int FL_Z  = 1;
	localparam int FL_OV = 2;
	localparam int FL_N  = 3;
	localparam int FL_HC = 8;
	localparam logic [15:0] FLAG_MASK  = 16'h010f;
	localparam logic [15:0] FLAG_RESET = 16'h0000;
	localparam logic [7:0]  PAGE_RESET = 8'h00;

	// bus map
	localparam logic [11:0] A_PAGE  = 12'h000;
	localparam logic [11:0] A_FLAGS = 12'h004;
	localparam logic [11:0] A_STATE = 12'h008;
	localparam logic [11:0] A_WREG  = 12'h040;
	localparam logic [11:0] A_WMASK = 12'hfc0;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : ssx_pkg

// [design/ssx_exec.sv]
// execution unit for reverse subtract, byte/nibble swap and table read high
// assumes: variable-latency data memory and program memory ports with ready
// handshakes, one AHB-Lite master, instructions offered with a valid/ready pair
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module ssx_exec
	import ssx_pkg::*;
(
	input  wire logic              CLK_I,
	input  wire logic              RESET_N_I,
	input  wire logic              INSTR_VALID_I,
	input  wire logic [PM_W-1:0]   INSTR_I,
	output logic                   INSTR_READY_O,
	output logic                   INSTR_DONE_O,
	output logic [DATA_W-1:0]      DM_ADDR_O,
	output logic                   DM_RE_O,
	output logic                   DM_WE_O,
	output logic [1:0]             DM_BE_O,
	output logic [DATA_W-1:0]      DM_WDATA_O,
	input  wire logic [DATA_W-1:0] DM_RDATA_I,
	input  wire logic              DM_READY_I,
	output logic [PM_W-1:0]        PM_ADDR_O,
	output logic                   PM_RE_O,
	input  wire logic [PM_W-1:0]   PM_RDATA_I,
	input  wire logic              PM_VALID_I,
	input  wire logic              HSEL_I,
	input  wire logic [31:0]       HADDR_I,
	input  wire logic [1:0]        HTRANS_I,
	input  wire logic              HWRITE_I,
	input  wire logic [2:0]        HSIZE_I,
	input  wire logic [31:0]       HWDATA_I,
	input  wire logic              HREADY_I,
	output logic [31:0]            HRDATA_O,
	output logic                   HREADYOUT_O,
	output logic                   HRESP_O
);
	typedef enum logic [1:0] {ST_IDLE, ST_SRC, ST_DST} ssx_state_t;

	function automatic logic [15:0] ea_addr(input logic [2:0] m, input logic [15:0] p,
		input logic b);
		logic [15:0] st;
		st = b ? STEP_BYTE : STEP_WORD;
		unique case (m)
			MD_PRE_INC: ea_addr = p + st;
			MD_PRE_DEC: ea_addr = p - st;
			default:    ea_addr = p;
		endcase
	endfunction : ea_addr

	function automatic logic [15:0] ea_next(input logic [2:0] m, input logic [15:0] p,
		input logic b);
		logic [15:0] st;
		st = b ? STEP_BYTE : STEP_WORD;
		unique case (m)
			MD_PRE_INC, MD_POST_INC: ea_next = p + st;
			MD_PRE_DEC, MD_POST_DEC: ea_next = p - st;
			default:                 ea_next = p;
		endcase
	endfunction : ea_next

	function automatic logic [15:0] sub_flags(input logic [15:0] s, input logic [15:0] b,
		input logic bm);
		logic [8:0]  d8;
		logic [16:0] d16;
		logic [4:0]  dn;
		sub_flags = '0;
		dn  = {1'b0, s[3:0]} - {1'b0, b[3:0]};
		d8  = {1'b0, s[7:0]} - {1'b0, b[7:0]};
		d16 = {1'b0, s} - {1'b0, b};
		if (bm) begin
			sub_flags[FL_HC] = ~dn[4];
			sub_flags[FL_C]  = ~d8[8];
			sub_flags[FL_N]  = d8[7];
			sub_flags[FL_Z]  = (d8[7:0] == 8'h00);
			sub_flags[FL_OV] = (s[7] ^ b[7]) & (s[7] ^ d8[7]);
		end else begin
			sub_flags[FL_HC] = ~d8[8];
			sub_flags[FL_C]  = ~d16[16];
			sub_flags[FL_N]  = d16[15];
			sub_flags[FL_Z]  = (d16[15:0] == 16'h0000);
			sub_flags[FL_OV] = (s[15] ^ b[15]) & (s[15] ^ d16[15]);
		end
	endfunction : sub_flags

	logic [DATA_W-1:0] wreg_q [NREG];
	ssx_state_t        st_q, st_d;
	logic [PAGE_W-1:0] page_q;
	logic [15:0]       flags_q;
	logic              tbl_q, byte_q, done_q;
	logic [2:0]        dmode_q;
	logic [3:0]        dreg_q;
	logic [15:0]       base_q, addr_q, res_q;
	logic              act_q, hwr_q;
	logic [11:0]       haddr_q;

	// instruction fields
	logic [3:0]  f_base, f_dreg, f_sreg;
	logic [2:0]  f_dmd, f_smd;
	logic        f_byte, is_rsub, is_swap, is_tbl;
	assign f_base = INSTR_I[F_BASE_HI:F_BASE_LO];
	assign f_byte = INSTR_I[F_BYTE];
	assign f_dmd  = INSTR_I[F_DMD_HI:F_DMD_LO];
	assign f_dreg = INSTR_I[F_DRG_HI:F_DRG_LO];
	assign f_smd  = INSTR_I[F_SMD_HI:F_SMD_LO];
	assign f_sreg = INSTR_I[F_SRG_HI:F_SRG_LO];
	assign is_rsub = (INSTR_I[PM_W-1:F_OP5_LO] == OPC_RSUB);
	assign is_tbl  = (INSTR_I[PM_W-1:F_OP9_LO] == OPC_TBLH);
	assign is_swap = (INSTR_I[PM_W-1:F_OP9_LO] == OPC_SWAP)
		&& (INSTR_I[F_ZERO_HI:F_ZERO_LO] == SWAP_ZERO);

	logic        bus_wr, take, have_res, fl_we, w_we, done_d, byte_c, dm_byte_rd;
	logic [15:0] res_v, fl_v, w_val, opnd, addr_d, res_d, cur_w_d;
	logic [3:0]  w_idx, cur_dreg;
	logic [2:0]  cur_dmd;
	logic        wait_bus;

	assign bus_wr      = act_q & hwr_q;
	assign wait_bus    = bus_wr & (st_q != ST_IDLE);
	assign INSTR_READY_O = (st_q == ST_IDLE) & ~bus_wr;
	assign take        = INSTR_VALID_I & INSTR_READY_O;
	assign cur_dmd     = (st_q == ST_IDLE) ? f_dmd : dmode_q;
	assign cur_dreg    = (st_q == ST_IDLE) ? f_dreg : dreg_q;
	assign byte_c      = (st_q == ST_IDLE) ? f_byte : byte_q;
	assign cur_w_d     = wreg_q[cur_dreg];
	assign dm_byte_rd  = addr_q[0];

	always_comb begin
		st_d = st_q;
		have_res = 1'b0;
		fl_we = 1'b0;
		w_we = 1'b0;
		w_idx = '0;
		w_val = '0;
		done_d = 1'b0;
		res_v = '0;
		fl_v = '0;
		opnd = '0;
		addr_d = addr_q;
		res_d = res_q;
		unique case (st_q)
			ST_IDLE: begin
				if (take && is_swap) begin
					w_we = 1'b1;
					w_idx = f_sreg;
					if (f_byte)
						w_val = {wreg_q[f_sreg][15:8], wreg_q[f_sreg][3:0],
							wreg_q[f_sreg][7:4]};
					else
						w_val = {wreg_q[f_sreg][7:0], wreg_q[f_sreg][15:8]};
					done_d = 1'b1;
				end else if (take && is_rsub && f_smd == MD_DIRECT) begin
					opnd = wreg_q[f_sreg];
					res_v = opnd - wreg_q[f_base];
					fl_v = sub_flags(opnd, wreg_q[f_base], f_byte);
					fl_we = 1'b1;
					have_res = 1'b1;
				end else if (take && (is_rsub || is_tbl)) begin
					// tbl source is always indirect, direct code acts as indirect
					w_we = 1'b1;
					w_idx = f_sreg;
					w_val = ea_next(f_smd, wreg_q[f_sreg], f_byte);
					addr_d = ea_addr(f_smd, wreg_q[f_sreg], f_byte);
					st_d = ST_SRC;
				end
			end
			ST_SRC: begin
				if (tbl_q && PM_VALID_I) begin
					if (byte_q)
						res_v = addr_q[0] ? 16'h0000 : {8'h00, PM_RDATA_I[23:16]};
					else
						res_v = {8'h00, PM_RDATA_I[23:16]};
					have_res = 1'b1;
				end else if (!tbl_q && DM_READY_I) begin
					if (byte_q)
						opnd = {8'h00, dm_byte_rd ? DM_RDATA_I[15:8] : DM_RDATA_I[7:0]};
					else
						opnd = DM_RDATA_I;
					res_v = opnd - base_q;
					fl_v = sub_flags(opnd, base_q, byte_q);
					fl_we = 1'b1;
					have_res = 1'b1;
				end
			end
			ST_DST: begin
				if (DM_READY_I) begin
					done_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (have_res) begin
			if (cur_dmd == MD_DIRECT) begin
				w_we = 1'b1;
				w_idx = cur_dreg;
				w_val = byte_c ? {cur_w_d[15:8], res_v[7:0]} : res_v;
				done_d = 1'b1;
				st_d = ST_IDLE;
			end else begin
				w_we = 1'b1;
				w_idx = cur_dreg;
				w_val = ea_next(cur_dmd, cur_w_d, byte_c);
				addr_d = ea_addr(cur_dmd, cur_w_d, byte_c);
				res_d = res_v;
				st_d = ST_DST;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			st_q <= ST_IDLE;
			done_q <= 1'b0;
			addr_q <= '0;
			res_q <= '0;
		end else begin
			st_q <= st_d;
			done_q <= done_d;
			addr_q <= addr_d;
			res_q <= res_d;
		end
	end

	// instruction context held across the memory phases
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tbl_q <= 1'b0;
			byte_q <= 1'b0;
			dmode_q <= MD_DIRECT;
			dreg_q <= '0;
			base_q <= '0;
		end else if (take) begin
			tbl_q <= is_tbl;
			byte_q <= f_byte;
			dmode_q <= f_dmd;
			dreg_q <= f_dreg;
			base_q <= wreg_q[f_base];
		end
	end

	// working registers: execution port, else bus writes while idle
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int i = 0; i < NREG; i++)
				wreg_q[i] <= '0;
		end else if (w_we) begin
			wreg_q[w_idx] <= w_val;
		end else if (bus_wr && !wait_bus && (haddr_q & A_WMASK) == A_WREG) begin
			wreg_q[haddr_q[5:2]] <= HWDATA_I[15:0];
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			flags_q <= FLAG_RESET;
		end else if (fl_we) begin
			flags_q <= (flags_q & ~FLAG_MASK) | (fl_v & FLAG_MASK);
		end else if (bus_wr && !wait_bus && haddr_q == A_FLAGS) begin
			flags_q <= HWDATA_I[15:0] & FLAG_MASK;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			page_q <= PAGE_RESET;
		else if (bus_wr && !wait_bus && haddr_q == A_PAGE)
			page_q <= HWDATA_I[PAGE_W-1:0];
	end

	// AHB-Lite address phase capture; writes stall while an instruction runs
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			act_q <= 1'b0;
			hwr_q <= 1'b0;
			haddr_q <= '0;
		end else if (HREADY_I) begin
			act_q <= HSEL_I & (HTRANS_I == HTRANS_NONSEQ);
			hwr_q <= HWRITE_I;
			haddr_q <= HADDR_I[11:0];
		end
	end

	always_comb begin
		HRDATA_O = '0;
		if (act_q && !hwr_q) begin
			if ((haddr_q & A_WMASK) == A_WREG)
				HRDATA_O = {16'h0000, wreg_q[haddr_q[5:2]]};
			else if (haddr_q == A_PAGE)
				HRDATA_O = {24'h000000, page_q};
			else if (haddr_q == A_FLAGS)
				HRDATA_O = {16'h0000, flags_q};
			else if (haddr_q == A_STATE)
				HRDATA_O = {31'h0, st_q != ST_IDLE};
		end
	end

	assign HREADYOUT_O  = ~wait_bus;
	assign HRESP_O      = 1'b0;
	assign INSTR_DONE_O = done_q;
	assign DM_ADDR_O    = addr_q;
	assign DM_RE_O      = (st_q == ST_SRC) & ~tbl_q;
	assign DM_WE_O      = (st_q == ST_DST);
	assign DM_BE_O      = byte_q ? (addr_q[0] ? 2'h2 : 2'h1) : 2'h3;
	assign DM_WDATA_O   = byte_q ? {res_q[7:0], res_q[7:0]} : res_q;
	assign PM_ADDR_O    = {page_q, addr_q};
	assign PM_RE_O      = (st_q == ST_SRC) & tbl_q;
endmodule : ssx_exec

// [tb/ssx_exec_checker.sv]
// concurrent checks on the execution block's instruction and memory ports
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
module ssx_exec_checker
	import ssx_pkg::*;
(
	input wire logic              CLK_I,
	input wire logic              RESET_N_I,
	input wire logic              INSTR_VALID_I,
	input wire logic [PM_W-1:0]   INSTR_I,
	input wire logic              INSTR_READY_O,
	input wire logic              INSTR_DONE_O,
	input wire logic [DATA_W-1:0] DM_ADDR_O,
	input wire logic              DM_RE_O,
	input wire logic              DM_WE_O,
	input wire logic [1:0]        DM_BE_O,
	input wire logic [DATA_W-1:0] DM_WDATA_O,
	input wire logic              DM_READY_I,
	input wire logic [PM_W-1:0]   PM_ADDR_O,
	input wire logic              PM_RE_O,
	input wire logic              PM_VALID_I
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	logic take, is_swap, is_rsub, is_tblh;
	assign take    = INSTR_VALID_I && INSTR_READY_O;
	assign is_swap = INSTR_I[23:15] == OPC_SWAP && INSTR_I[13:4] == SWAP_ZERO;
	assign is_rsub = INSTR_I[23:19] == OPC_RSUB;
	assign is_tblh = INSTR_I[23:15] == OPC_TBLH;

	swap_done_a: assert property (take && is_swap |=> INSTR_DONE_O)
		else $error("swap did not finish in one cycle");
	rsub_fast_a: assert property (take && is_rsub && INSTR_I[13:11] == MD_DIRECT &&
		INSTR_I[6:4] == MD_DIRECT |=> INSTR_DONE_O) else $error("direct subtract slow");
	tblh_fetch_a: assert property (take && is_tblh |=> PM_RE_O && !DM_RE_O)
		else $error("table read did not fetch program word");
	bad_opc_a: assert property (take && !(is_swap || is_rsub || is_tblh) |=> !INSTR_DONE_O)
		else $error("unknown opcode completed");
	pm_hold_a: assert property (PM_RE_O && !PM_VALID_I |=> PM_RE_O && $stable(PM_ADDR_O))
		else $error("program read dropped or moved");
	dm_hold_a: assert property (DM_RE_O && !DM_READY_I |=> DM_RE_O && $stable(DM_ADDR_O))
		else $error("data read dropped or moved");
	lane_pick_a: assert property (DM_WE_O |-> DM_BE_O == 2'h3 ||
		DM_BE_O == (DM_ADDR_O[0] ? 2'h2 : 2'h1)) else $error("byte lanes wrong");
	byte_dup_a: assert property (DM_WE_O && DM_BE_O != 2'h3 |->
		DM_WDATA_O[15:8] == DM_WDATA_O[7:0]) else $error("byte write data not on both lanes");
	busy_block_a: assert property (DM_RE_O || DM_WE_O || PM_RE_O |-> !INSTR_READY_O)
		else $error("instruction taken while busy");
	wr_done_a: assert property (DM_WE_O && DM_READY_I |=> INSTR_DONE_O)
		else $error("no done after destination write");
	cover property (take && is_rsub);
	cover property (take && is_tblh);
	cover property (DM_WE_O && DM_READY_I && DM_BE_O != 2'h3);
endmodule : ssx_exec_checker

bind ssx_exec ssx_exec_checker chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
	.INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .INSTR_READY_O(INSTR_READY_O),
	.INSTR_DONE_O(INSTR_DONE_O), .DM_ADDR_O(DM_ADDR_O), .DM_RE_O(DM_RE_O), .DM_WE_O(DM_WE_O),
	.DM_BE_O(DM_BE_O), .DM_WDATA_O(DM_WDATA_O), .DM_READY_I(DM_READY_I),
	.PM_ADDR_O(PM_ADDR_O), .PM_RE_O(PM_RE_O), .PM_VALID_I(PM_VALID_I));

// [tb/ssx_mem_model.sv]
// data memory and program memory behind the execution block
// assumes requests are held until ready; answer delay set by dly_i
`timescale 1ns/1ps
module ssx_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  dly_i,
	input  wire logic [15:0] dm_addr_i,
	input  wire logic        dm_re_i,
	input  wire logic        dm_we_i,
	input  wire logic [1:0]  dm_be_i,
	input  wire logic [15:0] dm_wdata_i,
	output logic      [15:0] dm_rdata_o,
	output logic             dm_ready_o,
	input  wire logic [23:0] pm_addr_i,
	input  wire logic        pm_re_i,
	output logic      [23:0] pm_rdata_o,
	output logic             pm_valid_o
);
	logic [15:0] mem [0:32767];
	logic [3:0]  cnt_q;
	logic [15:0] last_q;
	assign dm_ready_o = (dm_re_i || dm_we_i) && cnt_q == dly_i;
	assign pm_valid_o = pm_re_i && cnt_q == dly_i;
	// outside an answer the lines carry a value that changes every cycle
	assign dm_rdata_o = (dm_re_i && dm_ready_o) ? mem[dm_addr_i[15:1]] : ~last_q;
	assign pm_rdata_o = pm_valid_o ? {pm_addr_i[7:0] ^ pm_addr_i[23:16], pm_addr_i[15:0]}
		: ~{last_q[7:0], last_q};
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q  <= 4'h0;
			last_q <= 16'h0;
		end else begin
			last_q <= dm_rdata_o;
			if (dm_ready_o || pm_valid_o || !(dm_re_i || dm_we_i || pm_re_i))
				cnt_q <= 4'h0;
			else
				cnt_q <= cnt_q + 4'h1;
		end
	end
	always @(posedge clk_i) begin
		if (dm_we_i && dm_ready_o && dm_be_i[0])
			mem[dm_addr_i[15:1]][7:0] <= dm_wdata_i[7:0];
		if (dm_we_i && dm_ready_o && dm_be_i[1])
			mem[dm_addr_i[15:1]][15:8] <= dm_wdata_i[15:8];
	end
endmodule : ssx_mem_model

// [tb/ssx_exec_tb.sv]
// self-checking bench: registers over AHB-Lite, instructions on the valid/ready port
// assumes the memory model answers with a delay set per test
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module ssx_exec_tb
	import ssx_pkg::*;
;
	logic        clk = 0, rst_n = 0, valid = 0, hsel = 0, hwr = 0;
	logic [23:0] instr = '0;
	logic [1:0]  htr = '0;
	logic [31:0] haddr = '0, hwd = '0, r;
	logic [15:0] nxt, use_a;
	logic [3:0]  dly = '0;
	wire  [31:0] hrd;
	wire         ready, done, dm_re, dm_we, dm_rdy, pm_re, pm_vld, hro, hresp;
	wire  [15:0] dm_a, dm_wdat, dm_rd;
	wire  [1:0]  dm_be;
	wire  [23:0] pm_a, pm_rd;
	int          err_total = 0, n_checks = 0;
	always #10 clk = ~clk;
	ssx_exec dut (.CLK_I(clk), .RESET_N_I(rst_n), .INSTR_VALID_I(valid), .INSTR_I(instr),
		.INSTR_READY_O(ready), .INSTR_DONE_O(done), .DM_ADDR_O(dm_a), .DM_RE_O(dm_re),
		.DM_WE_O(dm_we), .DM_BE_O(dm_be), .DM_WDATA_O(dm_wdat), .DM_RDATA_I(dm_rd),
		.DM_READY_I(dm_rdy), .PM_ADDR_O(pm_a), .PM_RE_O(pm_re), .PM_RDATA_I(pm_rd),
		.PM_VALID_I(pm_vld), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htr), .HWRITE_I(hwr),
		.HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hro), .HRDATA_O(hrd),
		.HREADYOUT_O(hro), .HRESP_O(hresp));
	ssx_mem_model mem_m (.clk_i(clk), .rst_n_i(rst_n), .dly_i(dly), .dm_addr_i(dm_a),
		.dm_re_i(dm_re), .dm_we_i(dm_we), .dm_be_i(dm_be), .dm_wdata_i(dm_wdat),
		.dm_rdata_o(dm_rd), .dm_ready_o(dm_rdy), .pm_addr_i(pm_a), .pm_re_i(pm_re),
		.pm_rdata_o(pm_rd), .pm_valid_o(pm_vld));
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htr <= HTRANS_NONSEQ;
		haddr <= {20'h0, a};
		hwr <= w;
		do @(posedge clk); while (hro !== 1'b1);
		htr <= 2'h0;
		hsel <= 1'b0;
		hwd <= d;
		do @(posedge clk); while (hro !== 1'b1);
		r = hrd;
	endtask : ahb
	task wreg(input int n, input logic [15:0] v);
		ahb(1'b1, A_WREG + 12'(4 * n), {16'h0, v});
	endtask : wreg
	task chkreg(input string nm, input int n, input logic [15:0] e);
		ahb(1'b0, A_WREG + 12'(4 * n), 32'h0);
		`CHK(nm, e, r[15:0])
	endtask : chkreg
	task exec(input logic [23:0] w, input bit want);
		int k;
		@(posedge clk);
		valid <= 1'b1;
		instr <= w;
		do @(posedge clk); while (ready !== 1'b1);
		valid <= 1'b0;
		k = 0;
		while (want && done !== 1'b1 && k < 40) begin
			@(posedge clk);
			k++;
		end
		if (want)
			`CHK("done", 1'b1, done)
		repeat (2) @(posedge clk);
	endtask : exec
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		ahb(1'b0, 12'h800, 32'h0);
		`CHK("unmapped", 32'h0, r)
		wreg(0, 16'h8095);
		exec(24'hfd8000, 1);
		chkreg("swap word", 0, 16'h9580);
		wreg(0, 16'hab87);
		ahb(1'b1, A_FLAGS, 32'h0103);
		exec(24'hfdc000, 1);
		chkreg("swap byte", 0, 16'hab78);
		ahb(1'b0, A_FLAGS, 32'h0);
		`CHK("swap flags", 16'h0103, r[15:0])
		$display("test swap end");
		wreg(0, 16'h1732);
		wreg(1, 16'h7844);
		wreg(2, 16'h1001);
		mem_m.mem[15'h0800] = 16'h5555;
		dly <= 4'h1;
		exec(24'h104901, 1);
		`CHK("rsub byte mem", 16'h1255, mem_m.mem[15'h0800])
		ahb(1'b0, A_FLAGS, 32'h0);
		`CHK("rsub byte flags", 16'h0101, r[15:0])
		exec(24'h104001, 1);
		chkreg("rsub byte reg", 0, 16'h1712);
		wreg(7, 16'h2450);
		wreg(8, 16'h1808);
		wreg(9, 16'h2022);
		mem_m.mem[15'h0c04] = 16'h92e4;
		dly <= 4'h3;
		exec(24'h139cb8, 1);
		`CHK("rsub word mem", 16'h6e94, mem_m.mem[15'h1011])
		chkreg("rsub src ptr", 8, 16'h180a);
		chkreg("rsub dst ptr", 9, 16'h2024);
		ahb(1'b0, A_FLAGS, 32'h0);
		`CHK("rsub word flags", 16'h0105, r[15:0])
		$display("test subtract end");
		ahb(1'b1, A_PAGE, 32'h1);
		for (int m = 1; m <= 5; m++) begin
			wreg(6, 16'h3406);
			wreg(8, 16'h65b1);
			dly <= 4'(m % 3);
			nxt = (m == 1) ? 16'h3406 : (m == 2 || m == 4) ? 16'h3404 : 16'h3408;
			use_a = (m >= 4) ? nxt : 16'h3406;
			exec(24'hba8406 | 24'(m << 4), 1);
			chkreg("tblh data", 8, {8'h0, use_a[7:0] ^ 8'h01});
			chkreg("tblh ptr", 6, nxt);
		end
		ahb(1'b0, A_FLAGS, 32'h0);
		`CHK("tblh flags", 16'h0105, r[15:0])
		for (int o = 0; o < 2; o++) begin
			wreg(0, 16'h0812 | 16'(o));
			wreg(1, 16'h0f71);
			exec(24'hbac0b0, 1);
			chkreg("tblh byte", 1, o ? 16'h0f00 : 16'h0f13);
			chkreg("tblh byte ptr", 0, 16'h0813 + 16'(o));
		end
		$display("test table read end");
		exec(24'h000000, 0);
		chkreg("ignored opcode", 1, 16'h0f00);
		$display("test unknown end");
		summarize();
	end
endmodule : ssx_exec_tb
